//--- rtl/amc_defs.svh
// constants for the converter mux, frame and serial port control block
`ifndef AMC_DEFS_SVH
`define AMC_DEFS_SVH
// configuration word layout, first bit shifted in lands at the top
`define AMC_CFG_W 7
`define AMC_CFG_PAIRING 6
`define AMC_CFG_SWAP 5
`define AMC_CFG_IDX_HI 4
`define AMC_CFG_IDX_LO 3
`define AMC_CFG_REMAP 2
`define AMC_CFG_RANGE 1
`define AMC_CFG_PDOWN 0
`define AMC_CFG_RST 7'h00
`define AMC_CFG_FULL 3'h7
// result width and channel constants
`define AMC_RES_W 16
`define AMC_RES_MSB 15
`define AMC_RES_RST 16'h0000
`define AMC_CH_SHARED 3'h7
// timing
`define AMC_CLK_MHZ 100
`define AMC_CLK_KHZ 100000
`define AMC_CONV_TIME_NS 3000
`define AMC_CONV_CYC ((`AMC_CONV_TIME_NS * `AMC_CLK_MHZ + 999) / 1000)
`define AMC_WAKE_TIME_MS 60
`define AMC_WAKE_CYC (`AMC_WAKE_TIME_MS * `AMC_CLK_KHZ)
// wishbone register byte offsets
`define AMC_REG_RAW 8'h00
`define AMC_REG_STAT 8'h04
`define AMC_REG_RES 8'h08
`define AMC_REG_CFG 8'h0C
`endif

//--- rtl/amc_pkg.sv
// types for the converter control block
package amc_pkg;
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_CONV = 2'b01,
      ST_NAP = 2'b10,
      ST_SLEEP = 2'b11
   } amc_state_e;
endpackage : amc_pkg

//--- rtl/amc_top.sv
// converter control: mux decode, frame/convert sequencing, serial port
// Contract
// - seven bit word, fixed field order
// - differential pair chosen, swap flips polarity
// - single ended channel against ground
// - channel seven becomes shared negative input
// - rising frame edge starts a conversion
// - frame low after conversion shifts result
// - bipolar two's complement, unipolar straight binary
// - start edges ignored while converting
// - power down bit sleeps, wake needs 60ms
// - frame high after conversion enters nap
`timescale 1ns/1ps
`include "amc_defs.svh"
module amc_top
   import amc_pkg::*;
#(
   parameter int WAKE_CYC = `AMC_WAKE_CYC
)
(
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // wishbone slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // serial link pins
   input wire logic convert_frame_i,
   input wire logic shift_clock_i,
   input wire logic config_in_i,
   output logic result_out_o,
   output logic result_oe_o,
   // analog mux selection and power state
   output logic [2:0] mux_pos_o,
   output logic [2:0] mux_neg_o,
   output logic mux_neg_gnd_o,
   output logic converting_o,
   output logic nap_o,
   output logic sleep_o
);
   localparam logic [8:0] CONV_LAST = 9'(`AMC_CONV_CYC - 1);
   localparam logic [22:0] WAKE_LOAD = 23'(WAKE_CYC);

   amc_state_e state_ff, nxt_state;
   logic frame_m_ff, frame_s_ff, frame_d_ff;
   logic sck_m_ff, sck_s_ff, sck_d_ff;
   logic din_m_ff, din_s_ff;
   logic [`AMC_CFG_W-1:0] cfg_ff, cin_ff;
   logic [2:0] cin_cnt_ff;
   logic [8:0] conv_cnt_ff;
   logic [22:0] wake_cnt_ff;
   logic [`AMC_RES_W-1:0] raw_ff, res_ff, sr_ff;
   logic out_ff, oe_ff, sleep_ff, nap_ff, conv_ff;
   logic [2:0] pos_ff, neg_ff;
   logic gnd_ff, ack_ff;
   logic [31:0] dat_ff;

   // pins pass two flops; the first stage is read by nothing else
   always_ff @(posedge clk_i)
   begin
      frame_m_ff <= convert_frame_i;
      frame_s_ff <= frame_m_ff;
      frame_d_ff <= frame_s_ff;
      sck_m_ff <= shift_clock_i;
      sck_s_ff <= sck_m_ff;
      sck_d_ff <= sck_s_ff;
      din_m_ff <= config_in_i;
      din_s_ff <= din_m_ff;
   end

   // edge detection on synchronised copies
   wire frame_rise = frame_s_ff & ~frame_d_ff;
   wire frame_fall = ~frame_s_ff & frame_d_ff;
   wire sck_rise = sck_s_ff & ~sck_d_ff;
   wire sck_fall = ~sck_s_ff & sck_d_ff;
   wire port_state = (state_ff == ST_IDLE) || (state_ff == ST_SLEEP);
   wire port_open = port_state & ~frame_s_ff;
   wire conv_done = (state_ff == ST_CONV) && (conv_cnt_ff == CONV_LAST);
   wire word_full = (cin_cnt_ff == `AMC_CFG_FULL);
   wire apply_word = frame_rise & port_state & word_full;
   // a partial word keeps the previous setting
   wire [`AMC_CFG_W-1:0] cfg_next = apply_word ? cin_ff : cfg_ff;
   wire pd_next = cfg_next[`AMC_CFG_PDOWN];

   wire f_pairing = cfg_next[`AMC_CFG_PAIRING];
   wire f_swap = cfg_next[`AMC_CFG_SWAP];
   wire [1:0] f_pair = {cfg_next[`AMC_CFG_IDX_HI], cfg_next[`AMC_CFG_IDX_LO]};
   wire f_remap = cfg_next[`AMC_CFG_REMAP];
   // positive side is pair index twice plus swap bit
   wire [2:0] dec_pos = {f_pair, f_swap};
   wire [2:0] dec_pair = {f_pair, ~f_swap};
   // shared return only for positives 0..6; 7 falls back to ground
   wire use_shared = f_pairing & f_remap & (dec_pos != `AMC_CH_SHARED);
   wire [2:0] dec_neg = use_shared ? `AMC_CH_SHARED : dec_pair;
   wire dec_gnd = f_pairing & ~use_shared;

   // offset code to two's complement by msb flip when bipolar
   wire res_unsigned = cfg_ff[`AMC_CFG_RANGE];
   wire [`AMC_RES_W-1:0] fmt_res = res_unsigned ? raw_ff :
      {~raw_ff[`AMC_RES_MSB], raw_ff[`AMC_RES_MSB-1:0]};

   // sequencing
   always_comb
   begin
      nxt_state = state_ff;
      case (state_ff)
         ST_IDLE:
         begin
            if (frame_rise)
               nxt_state = pd_next ? ST_SLEEP : ST_CONV;
         end
         ST_CONV:
         begin
            if (conv_done)
               nxt_state = frame_s_ff ? ST_NAP : ST_IDLE;
         end
         ST_NAP:
         begin
            if (frame_fall)
               nxt_state = ST_IDLE;
         end
         ST_SLEEP:
         begin
            // a word without the bit releases sleep
            if (frame_rise && !pd_next)
               nxt_state = ST_CONV;
         end
         default:
            nxt_state = ST_IDLE;
      endcase
   end

   // state and status outputs
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         state_ff <= ST_IDLE;
         nap_ff <= 1'b0;
         sleep_ff <= 1'b0;
         conv_ff <= 1'b0;
      end
      else
      begin
         state_ff <= nxt_state;
         nap_ff <= (nxt_state == ST_NAP);
         sleep_ff <= (nxt_state == ST_SLEEP);
         conv_ff <= (nxt_state == ST_CONV);
      end
   end

   // conversion timer on the internal clock
   always_ff @(posedge clk_i)
   begin
      if (rst_i || state_ff != ST_CONV)
         conv_cnt_ff <= 9'h000;
      else
         conv_cnt_ff <= conv_cnt_ff + 9'h001;
   end

   // wake timer; conversions run meanwhile but are flagged unsettled
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         wake_cnt_ff <= 23'h000000;
      else if (state_ff == ST_SLEEP && nxt_state == ST_CONV)
         wake_cnt_ff <= WAKE_LOAD;
      else if (wake_cnt_ff != 23'h000000)
         wake_cnt_ff <= wake_cnt_ff - 23'h000001;
   end

   // word shifted in msb first on shift clock rising edges
   always_ff @(posedge clk_i)
   begin
      if (rst_i || frame_fall)
      begin
         cin_ff <= `AMC_CFG_RST;
         cin_cnt_ff <= 3'h0;
      end
      else if (port_open && sck_rise && !word_full)
      begin
         cin_ff <= {cin_ff[`AMC_CFG_W-2:0], din_s_ff};
         cin_cnt_ff <= cin_cnt_ff + 3'h1;
      end
   end

   // word and mux take effect at the next start edge
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         cfg_ff <= `AMC_CFG_RST;
         pos_ff <= 3'h0;
         neg_ff <= 3'h1;
         gnd_ff <= 1'b0;
      end
      else if (apply_word)
      begin
         cfg_ff <= cin_ff;
         pos_ff <= dec_pos;
         neg_ff <= dec_neg;
         gnd_ff <= dec_gnd;
      end
   end

   // result loaded at completion, next bit on shift clock fall
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         res_ff <= `AMC_RES_RST;
         sr_ff <= `AMC_RES_RST;
         out_ff <= 1'b0;
         oe_ff <= 1'b0;
      end
      else
      begin
         oe_ff <= (nxt_state == ST_IDLE) & ~frame_s_ff;
         if (conv_done)
         begin
            res_ff <= fmt_res;
            out_ff <= fmt_res[`AMC_RES_MSB];
            sr_ff <= {fmt_res[`AMC_RES_MSB-1:0], 1'b0};
         end
         else if (state_ff == ST_IDLE && port_open && sck_fall)
         begin
            out_ff <= sr_ff[`AMC_RES_MSB];
            sr_ff <= {sr_ff[`AMC_RES_MSB-1:0], 1'b0};
         end
      end
   end

   // wishbone decode; ack one cycle after the request
   wire wb_req = wb_cyc_i & wb_stb_i;
   wire sel_raw = (wb_adr_i == `AMC_REG_RAW);
   wire sel_stat = (wb_adr_i == `AMC_REG_STAT);
   wire sel_res = (wb_adr_i == `AMC_REG_RES);
   wire sel_cfg = (wb_adr_i == `AMC_REG_CFG);
   wire [31:0] stat_word = {20'h00000, gnd_ff, neg_ff, pos_ff,
      (wake_cnt_ff == 23'h000000), sleep_ff, nap_ff, conv_ff, ~frame_s_ff};
   wire [31:0] rd_mux = sel_raw ? {16'h0000, raw_ff} :
      sel_stat ? stat_word :
      sel_res ? {16'h0000, res_ff} :
      sel_cfg ? {21'h000000, cin_cnt_ff, 1'b0, cfg_ff} : 32'h00000000;
   wire wr_raw = wb_req & ack_ff & wb_we_i & sel_raw;

   // bus answers; unmapped reads give zero and writes are dropped
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         ack_ff <= 1'b0;
         dat_ff <= 32'h00000000;
         raw_ff <= `AMC_RES_RST;
      end
      else
      begin
         ack_ff <= wb_req & ~ack_ff;
         if (wb_req && !ack_ff)
            dat_ff <= rd_mux;
         if (wr_raw && wb_sel_i[0])
            raw_ff[7:0] <= wb_dat_i[7:0];
         if (wr_raw && wb_sel_i[1])
            raw_ff[15:8] <= wb_dat_i[15:8];
      end
   end

   assign wb_ack_o = ack_ff;
   assign wb_dat_o = dat_ff;
   assign result_out_o = out_ff;
   assign result_oe_o = oe_ff;
   assign mux_pos_o = pos_ff;
   assign mux_neg_o = neg_ff;
   assign mux_neg_gnd_o = gnd_ff;
   assign converting_o = conv_ff;
   assign nap_o = nap_ff;
   assign sleep_o = sleep_ff;

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   chk_rise_starts_conv: assert property (
      frame_rise && state_ff == ST_IDLE && !pd_next |=> converting_o ##1 converting_o)
      else $error("start edge did not begin a conversion");
   chk_conv_ignores_edge: assert property (
      state_ff == ST_CONV && !conv_done |=> state_ff == ST_CONV)
      else $error("conversion left before completion");
   chk_nap_when_high: assert property (
      conv_done && frame_s_ff |=> nap_o && !result_oe_o)
      else $error("no nap after conversion with frame high");
   chk_port_opens: assert property (
      conv_done && !frame_s_ff |=> result_oe_o && result_out_o == res_ff[`AMC_RES_MSB])
      else $error("result msb not presented");
   chk_bipolar_fmt: assert property (
      conv_done && !res_unsigned |=> res_ff == {~$past(raw_ff[15]), $past(raw_ff[14:0])})
      else $error("bipolar result not two's complement");
   chk_unipolar_fmt: assert property (
      conv_done && res_unsigned |=> res_ff == $past(raw_ff))
      else $error("unipolar result not straight binary");
   chk_diff_pair: assert property (
      !cfg_ff[`AMC_CFG_PAIRING] |-> !mux_neg_gnd_o && mux_pos_o ==
      {cfg_ff[4:3], cfg_ff[5]} && mux_neg_o == {cfg_ff[4:3], ~cfg_ff[5]})
      else $error("differential pair mismatch");
   chk_single_gnd: assert property (
      cfg_ff[`AMC_CFG_PAIRING] && !cfg_ff[`AMC_CFG_REMAP] |->
      mux_neg_gnd_o && mux_pos_o == {cfg_ff[4:3], cfg_ff[5]})
      else $error("single ended not against ground");
   chk_shared_neg: assert property (
      cfg_ff[`AMC_CFG_PAIRING] && cfg_ff[`AMC_CFG_REMAP] && mux_pos_o != 3'h7 |->
      !mux_neg_gnd_o && mux_neg_o == 3'h7)
      else $error("shared negative not selected");
   chk_sleep_entry: assert property (
      frame_rise && state_ff == ST_IDLE && pd_next |=> sleep_o && !converting_o)
      else $error("power down word did not sleep");
   chk_word_applied: assert property (
      apply_word |=> cfg_ff == $past(cin_ff))
      else $error("shifted word not applied");

   cov_conv_nap: cover property (conv_done && frame_s_ff ##[1:20] frame_fall);
   cov_conv_open: cover property (conv_done && !frame_s_ff);
   cov_sleep_wake: cover property (sleep_o ##[1:1000] converting_o);
endmodule : amc_top

//--- verif/amc_host_model.sv
// host side serial master model for the converter control block
`timescale 1ns/1ps
module amc_host_model (
   // link pins
   output logic convert_frame_o,
   output logic shift_clock_o,
   output logic config_in_o,
   input wire logic result_out_i
);
   // frame idles high, shift clock stands still low outside frames
   initial
   begin
      convert_frame_o = 1'h1;
      shift_clock_o = 1'h0;
      config_in_o = 1'h0;
   end
   // one frame of nclk shift clocks at 125 ns, then a start edge
   task automatic xfer(input logic [6:0] w, input int nclk, output logic [15:0] r);
      convert_frame_o = 1'h0;
      #200;
      for (int i = 0; i < nclk; i++)
      begin
         // word msb first on rising shift edges
         config_in_o = (i < 7) ? w[6 - i] : ~config_in_o;
         #62.5 shift_clock_o = 1'h1;
         r[15 - i] = result_out_i;
         #62.5 shift_clock_o = 1'h0;
      end
      // released data line must not keep the last bit
      #200 config_in_o = ~config_in_o;
      // rising frame edge starts the conversion
      convert_frame_o = 1'h1;
   endtask : xfer
   // low pulse in mid conversion, pokes a start edge at a busy device
   task automatic blip();
      #500 convert_frame_o = 1'h0;
      #100 convert_frame_o = 1'h1;
   endtask : blip
endmodule : amc_host_model

//--- verif/tb_top.sv
// self-checking bench for the converter control block
`timescale 1ns/1ps
`include "amc_defs.svh"
module tb_top;
   logic clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
   logic [7:0] wb_adr_i;
   logic [3:0] wb_sel_i;
   logic [31:0] wb_dat_i, wb_dat_o, rd;
   logic convert_frame_i, shift_clock_i, config_in_i, result_out_o, result_oe_o;
   logic [2:0] mux_pos_o, mux_neg_o;
   logic mux_neg_gnd_o, converting_o, nap_o, sleep_o, range_q;
   // the result line has a pull-up: undriven it reads high, not the last bit
   wire sdo_line = result_oe_o ? result_out_o : 1'h1;
   logic [15:0] res, raw_q;
   int num_errors = 0;
   int n_checks = 0;

   // wake count shortened so the run stays short
   amc_top #(.WAKE_CYC(50)) u_dut (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i,
      .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .convert_frame_i,
      .shift_clock_i, .config_in_i, .result_out_o, .result_oe_o, .mux_pos_o,
      .mux_neg_o, .mux_neg_gnd_o, .converting_o, .nap_o, .sleep_o);
   amc_host_model u_host (.convert_frame_o(convert_frame_i), .shift_clock_o(shift_clock_i),
      .config_in_o(config_in_i), .result_out_i(sdo_line));

   // 100 MHz clock
   initial
   begin
      clk_i = 1'h0;
      forever #5 clk_i = ~clk_i;
   end

   task automatic stop_test();
      $display("checks %0d errors %0d", n_checks, num_errors);
      if (num_errors == 0 && n_checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : stop_test

   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
      n_checks++;
      if (got !== exp)
      begin
         $display("FAIL %0t %s", $time, msg);
         num_errors++;
      end
   endtask : chk

   // classic single cycle; ack read before this edge's updates land
   task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk_i);
      wb_cyc_i <= 1'h1;
      wb_stb_i <= 1'h1;
      wb_we_i <= we;
      wb_adr_i <= a;
      wb_dat_i <= d;
      do
      begin
         @(posedge clk_i);
         n++;
      end
      while (wb_ack_o !== 1'h1 && n < 20);
      rd = wb_dat_o;
      wb_cyc_i <= 1'h0;
      wb_stb_i <= 1'h0;
      if (wb_ack_o !== 1'h1)
      begin
         chk(0, 1, "no ack");
         stop_test();
      end
   endtask : wb

   // counts edges until converting_o reads v
   task automatic wait_conv(input logic v, output int n);
      n = 0;
      while (converting_o !== v && n < 1000)
      begin
         @(posedge clk_i);
         n++;
      end
      if (n >= 1000)
      begin
         chk(0, 1, "conversion wait ran out");
         stop_test();
      end
   endtask : wait_conv

   // expected mux as {pos, neg, gnd}
   function automatic logic [6:0] exp_mux(input logic [6:0] w);
      logic [2:0] p;
      p = {w[4], w[3], w[5]};
      if (!w[6])
         return {p, p ^ 3'h1, 1'h0};
      if (w[2] && p != 3'h7)
         return {p, 3'h7, 1'h0};
      return {p, 3'h0, 1'h1};
   endfunction : exp_mux

   // one frame with word w on raw code raw, optional start poke mid conversion
   task automatic convert(input logic [6:0] w, input logic [15:0] raw, input logic poke);
      logic [6:0] m;
      int n;
      m = exp_mux(w);
      wb(1'h1, `AMC_REG_RAW, {16'h0000, raw});
      u_host.xfer(w, 16, res);
      chk(res, range_q ? raw_q : raw_q ^ 16'h8000, "result word");
      wait_conv(1'h1, n);
      if (poke)
         fork
            u_host.blip();
         join_none
      chk({mux_pos_o, mux_neg_gnd_o}, {m[6:4], m[0]}, "mux plus or ground");
      if (!m[0])
         chk(mux_neg_o, m[3:1], "mux minus");
      wait_conv(1'h0, n);
      chk(n, `AMC_CONV_CYC, "conversion length");
      repeat (2) @(posedge clk_i);
      chk(nap_o, 1'h1, "nap with frame high");
      wb(1'h0, `AMC_REG_CFG, 32'h0);
      chk(rd[6:0], w, "applied word");
      raw_q = raw;
      range_q = w[1];
   endtask : convert

   // main sequence
   initial
   begin
      int n;
      rst_i = 1'h1;
      wb_cyc_i = 1'h0;
      wb_stb_i = 1'h0;
      wb_we_i = 1'h0;
      wb_adr_i = 8'h00;
      wb_sel_i = 4'h3;
      wb_dat_i = 32'h0;
      raw_q = 16'h0000;
      range_q = 1'h1;
      repeat (8) @(posedge clk_i);
      rst_i <= 1'h0;
      @(posedge clk_i);
      chk({result_oe_o, mux_pos_o, mux_neg_o, mux_neg_gnd_o, converting_o, nap_o, sleep_o},
         11'h010, "reset outputs");
      wb(1'h1, `AMC_REG_RAW, 32'h0000A5C3);
      wb(1'h0, `AMC_REG_RAW, 32'h0);
      chk(rd, 32'h0000A5C3, "raw readback");
      wb(1'h1, 8'h40, 32'hFFFFFFFF);
      wb(1'h0, 8'h40, 32'h0);
      chk(rd, 32'h0, "unmapped read");
      wb(1'h1, `AMC_REG_CFG, 32'h7F);
      wb(1'h0, `AMC_REG_CFG, 32'h0);
      chk(rd, 32'h0, "read only write ignored");
      // every mux code, both ranges, one poked conversion
      for (int i = 0; i < 32; i++)
         convert({i[4:0], i[0] ^ i[1], 1'h0}, 16'h1234 + 16'(i) * 16'h0F0F, i == 5);
      // a three bit word is dropped, the old word runs again
      u_host.xfer(7'h00, 3, res);
      wait_conv(1'h1, n);
      wait_conv(1'h0, n);
      wb(1'h0, `AMC_REG_CFG, 32'h0);
      chk(rd[6:0], 7'h7C, "partial word kept old");
      // power down word sleeps without converting, a later word wakes it
      u_host.xfer(7'h01, 16, res);
      chk(res, range_q ? raw_q : raw_q ^ 16'h8000, "result before sleep");
      repeat (10) @(posedge clk_i);
      chk({sleep_o, converting_o}, 2'h2, "sleep without conversion");
      // asleep the port stays undriven, so the next frame reads the pull-up
      raw_q = 16'hFFFF;
      range_q = 1'h1;
      convert(7'h00, 16'hFFFF, 1'h0);
      wb(1'h0, `AMC_REG_STAT, 32'h0);
      chk(rd[4:3], 2'h2, "awake and wake done");
      convert(7'h02, 16'h0001, 1'h0);
      stop_test();
   end
endmodule : tb_top
